// ===== rtl/sfp_front_end.sv
// What this block does
// (R1) Quad off, dedicated reset on: pin pauses
// (R2) Dedicated reset off: select bit picks pause/reset
// (R3) Pause freezes link, keeps partial command
// (R4) Paused and selected: serial output goes high-Z
// (R5) Pause released: link resumes where it stopped
// (R6) Reset pin low: reset mode, outputs high-Z
// (R7) Master avoids reset during internal writes
// (R8) Function bit 0 set disables dedicated reset
// (R9) Clock modes 0 and 3 only
// (R10) Sample on rising edge, drive from falling
// (R11) Dual: lanes zero and one bidirectional
// (R12) Quad: lanes zero to three bidirectional
// (R13) 4 KB sectors, 32/64 KB blocks
// (R14) Linear sectors, sector 2047 ends at top
// (R15) Quad enable: lane three is data only
// (R16) Pause ignored while deselected
package sfp_pkg;

	// ***********************************************************
	// Address map
	// ***********************************************************
	localparam int          ADDR_W       = 24;
	localparam int          SECTOR_SHIFT = 12;  // 4 KB sectors
	localparam int          BLK32_SHIFT  = 15;  // eight sectors
	localparam int          BLK64_SHIFT  = 16;  // sixteen sectors
	localparam int          TOP_BIT      = 22;
	localparam logic [23:0] TOP_ADDR     = 24'h7FFFFF;

	// ***********************************************************
	// Link framing and reset values
	// ***********************************************************
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
	localparam logic [7:0]  TX_HOLD_RST   = 8'hFF;

	typedef enum logic [1:0] {
		SFP_W1,
		SFP_W2,
		SFP_W4
	} sfp_width_t;

	typedef enum logic [1:0] {
		SFP_ROLE_PAUSE,
		SFP_ROLE_RESET,
		SFP_ROLE_DATA
	} sfp_role_t;

	typedef enum logic {
		SFP_PH_RX,
		SFP_PH_TX
	} sfp_phase_t;

endpackage : sfp_pkg

// ***************************************************************
// Shared-pin front end of the serial flash host port
// ***************************************************************
module sfp_front_end
	import sfp_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_sck,
	input  wire logic        i_cs_n,
	input  wire logic        i_lane_zero_in,
	input  wire logic        i_lane_one_in,
	input  wire logic        i_lane_two_in,
	input  wire logic        i_lane_three_in,
	output logic             o_lane_zero_out,
	output logic             o_lane_zero_oe,
	output logic             o_lane_one_out,
	output logic             o_lane_one_oe,
	output logic             o_lane_two_out,
	output logic             o_lane_two_oe,
	output logic             o_lane_three_out,
	output logic             o_lane_three_oe,
	input  wire logic        i_quad_lane_enable,
	input  wire logic        i_pin_function_select,
	input  wire logic        i_reset_pin_disable,
	input  wire logic        i_dual_mode,
	input  wire logic        i_quad_mode,
	input  wire logic        i_quad_command_mode,
	input  wire logic [3:0]  i_rx_len,
	input  wire logic        i_tx_load,
	input  wire logic [7:0]  i_tx_byte,
	input  wire logic [23:0] i_addr,
	output logic [7:0]       o_rx_byte,
	output logic             o_rx_valid,
	output logic [1:0]       o_pin_role,
	output logic             o_link_paused,
	output logic             o_link_in_reset,
	output logic [10:0]      o_sector,
	output logic [7:0]       o_block32,
	output logic [6:0]       o_block64,
	output logic             o_addr_in_range
);

	// ***********************************************************
	// Configuration carried into the link clock domain
	// ***********************************************************
	// Quasi-static: change only while deselected; needs two sck edges
	logic [9:0]  cfg_raw;
	logic [9:0]  cfg_lnk;
	sfp_role_t   role_lnk;
	sfp_role_t   role_clk;
	sfp_width_t  width_lnk;
	logic        hw_rst_act;
	logic        pause_now;
	logic        link_rst_n;
	logic        out_rst_n;

	assign cfg_raw = {i_rx_len, i_quad_command_mode, i_quad_mode,
		i_dual_mode, i_reset_pin_disable, i_pin_function_select,
		i_quad_lane_enable};

	sfp_sync #(.WIDTH(10)) u_cfg_sync (
		.i_clk   (i_sck),
		.i_rst_n (i_rst_n),
		.i_d     (cfg_raw),
		.o_q     (cfg_lnk)
	);

	// Role of the shared lane-three pin, same decode in both domains
	function automatic sfp_role_t sfp_role(input logic qe,
		input logic sel, input logic dis);
		sfp_role_t r;
		if (qe)
			r = SFP_ROLE_DATA;   // [R15]
		else if (dis && sel)
			r = SFP_ROLE_RESET;  // [R2] [R8]
		else
			r = SFP_ROLE_PAUSE;  // [R1] [R2]
		return r;
	endfunction : sfp_role

	// Lane width; quad needs the quad enable bit set
	always_comb begin
		role_lnk = sfp_role(cfg_lnk[0], cfg_lnk[1], cfg_lnk[2]);
		if (cfg_lnk[0] && (cfg_lnk[4] || cfg_lnk[5]))
			width_lnk = SFP_W4;  // [R12]
		else if (cfg_lnk[3])
			width_lnk = SFP_W2;  // [R11]
		else
			width_lnk = SFP_W1;
	end

	// Reset and pause act at once from the pins, without sck edges
	assign hw_rst_act = (role_lnk == SFP_ROLE_RESET) && !i_lane_three_in;
	assign pause_now  = (role_lnk == SFP_ROLE_PAUSE) && !i_lane_three_in
		&& !i_cs_n;                                  // [R16]
	assign link_rst_n = i_rst_n && !i_cs_n && !hw_rst_act;  // [R6]
	// Pause clears only the drivers, never the shift state
	assign out_rst_n  = link_rst_n && !pause_now;            // [R4]

	// ***********************************************************
	// Rising-edge receive and shift state
	// ***********************************************************
	sfp_phase_t  phase_reg;
	sfp_phase_t  phase_next;
	logic [3:0]  bit_cnt_reg;
	logic [3:0]  bit_cnt_next;
	logic [3:0]  byte_cnt_reg;
	logic [3:0]  byte_cnt_next;
	logic [7:0]  rx_shift_reg;
	logic [7:0]  rx_shift_next;
	logic [7:0]  tx_shift_reg;
	logic [7:0]  tx_shift_next;
	logic [7:0]  tx_hold_reg;
	logic [7:0]  tx_hold_next;
	logic [3:0]  step;
	logic [3:0]  bit_sum;
	logic        rx_done;

	// Sample on rising sck, in both clock modes; pause freezes all [R9]
	always_comb begin
		phase_next    = phase_reg;
		bit_cnt_next  = bit_cnt_reg;
		byte_cnt_next = byte_cnt_reg;
		rx_shift_next = rx_shift_reg;
		tx_shift_next = tx_shift_reg;
		rx_done       = 1'b0;
		case (width_lnk)
			SFP_W4:  step = 4'h4;
			SFP_W2:  step = 4'h2;
			default: step = 4'h1;
		endcase
		bit_sum = bit_cnt_reg + step;
		if (!pause_now) begin                       // [R3] [R5]
			bit_cnt_next = (bit_sum == BITS_PER_BYTE) ? 4'h0 : bit_sum;
			case (phase_reg)
				SFP_PH_RX: begin
					case (width_lnk)                       // [R10]
						SFP_W4: rx_shift_next = {rx_shift_reg[3:0],
							i_lane_three_in, i_lane_two_in,
							i_lane_one_in, i_lane_zero_in};
						SFP_W2: rx_shift_next = {rx_shift_reg[5:0],
							i_lane_one_in, i_lane_zero_in};
						default: rx_shift_next = {rx_shift_reg[6:0],
							i_lane_zero_in};
					endcase
					if (bit_sum == BITS_PER_BYTE) begin
						rx_done       = 1'b1;
						byte_cnt_next = byte_cnt_reg + 4'h1;
						if (byte_cnt_next == cfg_lnk[9:6]) begin
							phase_next    = SFP_PH_TX;
							tx_shift_next = tx_hold_reg;
						end
					end
				end
				SFP_PH_TX: begin
					if (bit_sum == BITS_PER_BYTE)
						tx_shift_next = tx_hold_reg;  // Repeat last byte
					else
						tx_shift_next = tx_shift_reg << step;
				end
				default: phase_next = SFP_PH_RX;
			endcase
		end
	end

	// Deselect or reset pin aborts the frame
	always_ff @(posedge i_sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			phase_reg    <= SFP_PH_RX;
			bit_cnt_reg  <= 4'h0;
			byte_cnt_reg <= 4'h0;
			rx_shift_reg <= 8'h00;
			tx_shift_reg <= 8'h00;
		end else begin
			phase_reg    <= phase_next;
			bit_cnt_reg  <= bit_cnt_next;
			byte_cnt_reg <= byte_cnt_next;
			rx_shift_reg <= rx_shift_next;
			tx_shift_reg <= tx_shift_next;
		end
	end

	// ***********************************************************
	// Received byte handed over by toggle
	// ***********************************************************
	logic [7:0]  rx_data_reg;
	logic [7:0]  rx_data_next;
	logic        rx_tgl_reg;
	logic        rx_tgl_next;

	// Kept across deselect so no false event at frame end
	always_comb begin
		rx_data_next = rx_done ? rx_shift_next : rx_data_reg;
		rx_tgl_next  = rx_tgl_reg ^ rx_done;
	end

	always_ff @(posedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_data_reg <= 8'h00;
			rx_tgl_reg  <= 1'b0;
		end else begin
			rx_data_reg <= rx_data_next;
			rx_tgl_reg  <= rx_tgl_next;
		end
	end

	// ***********************************************************
	// Falling-edge lane drivers
	// ***********************************************************
	logic [3:0]  lane_out_reg;
	logic [3:0]  lane_out_next;
	logic [3:0]  lane_oe_reg;
	logic [3:0]  lane_oe_next;
	logic [3:0]  lane_mask;
	logic [3:0]  lane_data;

	// Lane set and bit order per width; single drives lane one only
	always_comb begin
		case (width_lnk)
			SFP_W4: begin
				lane_mask = 4'hF;                          // [R12]
				lane_data = tx_shift_reg[7:4];
			end
			SFP_W2: begin
				lane_mask = 4'h3;                          // [R11]
				lane_data = {2'h0, tx_shift_reg[7:6]};
			end
			default: begin
				lane_mask = 4'h2;
				lane_data = {2'h0, tx_shift_reg[7], 1'b0};
			end
		endcase
	end

	// Drive from the falling edge so the master samples on rising
	generate
		for (genvar g = 0; g < 4; g++) begin : g_lane
			always_comb begin
				lane_oe_next[g]  = (phase_reg == SFP_PH_TX) && lane_mask[g];
				lane_out_next[g] = lane_data[g];              // [R10]
			end

			always_ff @(negedge i_sck or negedge out_rst_n) begin
				if (!out_rst_n) begin
					lane_oe_reg[g]  <= 1'b0;                  // [R4] [R6]
					lane_out_reg[g] <= 1'b0;
				end else begin
					lane_oe_reg[g]  <= lane_oe_next[g];
					lane_out_reg[g] <= lane_out_next[g];
				end
			end
		end
	endgenerate

	assign o_lane_zero_out  = lane_out_reg[0];
	assign o_lane_zero_oe   = lane_oe_reg[0];
	assign o_lane_one_out   = lane_out_reg[1];
	assign o_lane_one_oe    = lane_oe_reg[1];
	assign o_lane_two_out   = lane_out_reg[2];
	assign o_lane_two_oe    = lane_oe_reg[2];
	assign o_lane_three_out = lane_out_reg[3];
	assign o_lane_three_oe  = lane_oe_reg[3];

	// ***********************************************************
	// System clock side: status, handover, address map
	// ***********************************************************
	logic [2:0]  lnk_st;
	logic        tgl_seen_reg;
	logic        tgl_seen_next;
	logic [7:0]  rx_byte_reg;
	logic [7:0]  rx_byte_next;
	logic        rx_valid_reg;
	logic        rx_valid_next;
	logic [1:0]  role_reg;
	logic [1:0]  role_next;
	logic [10:0] sector_reg;
	logic [10:0] sector_next;
	logic [7:0]  blk32_reg;
	logic [7:0]  blk32_next;
	logic [6:0]  blk64_reg;
	logic [6:0]  blk64_next;
	logic        in_range_reg;
	logic        in_range_next;

	sfp_sync #(.WIDTH(3)) u_st_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_d     ({rx_tgl_reg, hw_rst_act, pause_now}),
		.o_q     (lnk_st)
	);

	// Byte stays stable 8, 4 or 2 sck edges by lane width, longer than the sync delay
	always_comb begin
		role_clk      = sfp_role(i_quad_lane_enable,
			i_pin_function_select, i_reset_pin_disable);
		role_next     = role_clk;
		tgl_seen_next = lnk_st[2];
		rx_valid_next = lnk_st[2] ^ tgl_seen_reg;
		rx_byte_next  = rx_valid_next ? rx_data_reg : rx_byte_reg;
		tx_hold_next  = i_tx_load ? i_tx_byte : tx_hold_reg;
		sector_next   = i_addr[TOP_BIT:SECTOR_SHIFT];      // [R14]
		blk32_next    = i_addr[TOP_BIT:BLK32_SHIFT];       // [R13]
		blk64_next    = i_addr[TOP_BIT:BLK64_SHIFT];       // [R13]
		in_range_next = (i_addr <= TOP_ADDR);              // [R14]
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			role_reg     <= 2'h0;
			tgl_seen_reg <= 1'b0;
			rx_valid_reg <= 1'b0;
			rx_byte_reg  <= 8'h00;
			tx_hold_reg  <= TX_HOLD_RST;
			sector_reg   <= 11'h000;
			blk32_reg    <= 8'h00;
			blk64_reg    <= 7'h00;
			in_range_reg <= 1'b0;
		end else begin
			role_reg     <= role_next;
			tgl_seen_reg <= tgl_seen_next;
			rx_valid_reg <= rx_valid_next;
			rx_byte_reg  <= rx_byte_next;
			tx_hold_reg  <= tx_hold_next;
			sector_reg   <= sector_next;
			blk32_reg    <= blk32_next;
			blk64_reg    <= blk64_next;
			in_range_reg <= in_range_next;
		end
	end

	assign o_pin_role      = role_reg;
	assign o_link_paused   = lnk_st[0];
	assign o_link_in_reset = lnk_st[1];
	assign o_rx_byte       = rx_byte_reg;
	assign o_rx_valid      = rx_valid_reg;
	assign o_sector        = sector_reg;
	assign o_block32       = blk32_reg;
	assign o_block64       = blk64_reg;
	assign o_addr_in_range = in_range_reg;

	// ***********************************************************
	// Checks
	// ***********************************************************
	property p_role_pause;
		@(posedge i_clk) disable iff (!i_rst_n)
		!i_quad_lane_enable && !i_reset_pin_disable
			|=> o_pin_role == 2'(SFP_ROLE_PAUSE);
	endproperty
	a_role_pause: assert property (p_role_pause) else  // [R1]
		$error("pin role not pause with dedicated reset on");

	property p_role_select;
		@(posedge i_clk) disable iff (!i_rst_n)
		!i_quad_lane_enable && i_reset_pin_disable
			|=> o_pin_role == ($past(i_pin_function_select) ?
			2'(SFP_ROLE_RESET) : 2'(SFP_ROLE_PAUSE));
	endproperty
	a_role_select: assert property (p_role_select) else  // [R2] [R8]
		$error("select bit did not set pin role");

	property p_role_data;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_quad_lane_enable |=> o_pin_role == 2'(SFP_ROLE_DATA);
	endproperty
	a_role_data: assert property (p_role_data) else  // [R15]
		$error("lane three not data with quad enabled");

	property p_pause_hiz;
		@(negedge i_sck) disable iff (!i_rst_n)
		pause_now |-> !o_lane_one_oe && !o_lane_zero_oe;
	endproperty
	a_pause_hiz: assert property (p_pause_hiz) else  // [R4]
		$error("output driven while paused");

	property p_pause_freeze;
		@(posedge i_sck) disable iff (!link_rst_n)
		pause_now ##1 pause_now |-> $stable(bit_cnt_reg)
			&& $stable(rx_shift_reg) && $stable(byte_cnt_reg);
	endproperty
	a_pause_freeze: assert property (p_pause_freeze) else  // [R3] [R5]
		$error("link state moved during pause");

	property p_reset_hiz;
		@(posedge i_clk) disable iff (!i_rst_n)
		hw_rst_act[*2] |-> lane_oe_reg == 4'h0 && bit_cnt_reg == 4'h0;
	endproperty
	a_reset_hiz: assert property (p_reset_hiz) else  // [R6]
		$error("reset pin low but link active");

	// Three samples cover the two-flop lag of the pause status
	property p_desel_no_pause;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_cs_n[*3] |-> !o_link_paused;
	endproperty
	a_desel_no_pause: assert property (p_desel_no_pause) else  // [R16]
		$error("pause seen while deselected");

	property p_rise_sample;
		@(posedge i_sck) disable iff (!link_rst_n)
		phase_reg == SFP_PH_RX && !pause_now && width_lnk == SFP_W1
			|=> rx_shift_reg[0] == $past(i_lane_zero_in);
	endproperty
	a_rise_sample: assert property (p_rise_sample) else  // [R10]
		$error("input bit not taken on rising edge");

	property p_lane_set;
		@(negedge i_sck) disable iff (!out_rst_n)
		phase_reg == SFP_PH_TX && width_lnk == SFP_W2 && !pause_now
			##1 !pause_now |-> lane_oe_reg == 4'h3;
	endproperty
	a_lane_set: assert property (p_lane_set) else  // [R11]
		$error("dual output lanes wrong");

	property p_sector_map;
		@(posedge i_clk) disable iff (!i_rst_n)
		1'b1 |=> o_sector == $past(i_addr[22:12])
			&& o_block64 == o_sector[10:4] && o_block32 == o_sector[10:3];
	endproperty
	a_sector_map: assert property (p_sector_map) else  // [R13] [R14]
		$error("sector or block number wrong");

endmodule : sfp_front_end

// ===== rtl/sfp_sync.sv
// ***************************************************************
// Two-stage level synchroniser
// ***************************************************************
module sfp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	// First stage feeds only the second stage, never any logic
	always_comb begin
		meta_next = i_d;
		sync_next = meta_reg;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign o_q = sync_reg;

endmodule : sfp_sync

// ===== test/sfp_spi_master.sv
// ***************************************************************
// Bus master model on the far side of the link pins
// ***************************************************************
module sfp_spi_master (
	output logic            o_sck,
	output logic            o_cs_n,
	output logic [3:0]      o_lane,
	input  wire logic [3:0] i_out,
	input  wire logic [3:0] i_oe,
	input  wire logic [1:0] i_stat
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       m3 = 1'b0;   // Clock idles high in mode 3
	logic [3:0] drv = 4'hC;  // Pause and protect pins idle high
	logic [3:0] en = 4'hD;   // Lane one belongs to the device
	logic [3:0] smp;
	logic [3:0] soe;
	logic [3:0] hold_oe;
	logic [1:0] hold_stat;
	int         oe_bad;

	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
	end

	// A released lane toggles so that stale data can never match
	assign o_lane = (i_oe & i_out) | (~i_oe & en & drv)
		| (~i_oe & ~en & {4{~o_sck}});

	// Shift on the falling edge, sample just before the rise
	task automatic cyc(input logic [3:0] d);
		o_sck = 1'b0;
		drv = d;
		#24;
		smp = o_lane;
		soe = i_oe;
		o_sck = 1'b1;
		#24;
	endtask : cyc

	// Mode 0 returns the clock low between frames
	task automatic park;
		if (!m3) begin
			o_sck = 1'b0;
			#24;
		end
	endtask : park

	// Config only crosses on link edges, so toggle while deselected
	task automatic setup(input logic mode3);
		m3 = mode3;
		repeat (2) cyc(drv);
		park;
	endtask : setup

	// Pause pin low across two junk bits
	task automatic pause;
		drv[3] = 1'b0;
		repeat (2) cyc(drv ^ 4'h1);
		hold_oe = soe;
		hold_stat = i_stat;
		drv[3] = 1'b1;
	endtask : pause

	// Send nin bytes MSB first, then read nout bytes back
	task automatic frame(input int w, input logic [7:0] tx, input int nin,
		input int nout, input int hold_at, output logic [7:0] rx);
		logic [3:0] msk;
		logic [3:0] dm;
		int         v;
		msk = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h2;
		dm = (w == 1) ? 4'h1 : msk;
		rx = 8'h00;
		oe_bad = 0;
		#7;
		o_cs_n = 1'b0;
		#24;
		for (int k = 0; k < (nin + nout) * 8 / w; k++) begin
			if (k == hold_at)
				pause();
			if (k < nin * 8 / w) begin
				v = (int'(tx) << ((k * w) % 8)) >> (8 - w);
				en = en | dm;
				cyc((drv & ~dm) | (4'(v) & dm));
			end else begin
				en = en & ~msk;  // Hand the lanes to the device
				cyc(drv);
				rx = 8'((rx << w) | ((w == 1) ? {3'h0, smp[1]} : smp & msk));
				if (soe !== msk)
					oe_bad++;
			end
		end
		park;
		o_cs_n = 1'b1;
		#24;
		drv = 4'hC;
		en = 4'hD;
	endtask : frame

endmodule : sfp_spi_master

// ===== test/test_serial_flash_pin_mode_front_end.sv
module test_serial_flash_pin_mode_front_end
	import sfp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [5:0]  cfg = 6'h00;  // qe, select, reset off, dual, quad, qcmd
	logic [3:0]  rx_len = 4'h1;
	logic        tx_load = 1'b0;
	logic [7:0]  tx_byte = 8'h00;
	logic [23:0] addr = 24'h000000;
	wire  [3:0]  lane;
	wire  [3:0]  l_out;
	wire  [3:0]  l_oe;
	wire         sck;
	wire         cs_n;
	logic [7:0]  rx_byte;
	logic [7:0]  rx_d;
	logic        rx_valid;
	logic        paused;
	logic        in_rst;
	logic        in_range;
	logic [1:0]  role;
	logic [10:0] sector;
	logic [7:0]  blk32;
	logic [6:0]  blk64;
	logic [7:0]  rxq[$];
	int          err_total;
	int          cmp_count;
	int          cycles;
	logic [5:0]  cfg_tab[4] = '{6'h00, 6'h04, 6'h22, 6'h21};
	int          w_tab[4] = '{1, 2, 4, 4};
	logic [23:0] a_tab[9] = '{24'h000000, 24'h000FFF, 24'h001000,
		24'h00F000, 24'h010000, 24'h3FF000, 24'h7FF000, 24'h7FFFFF,
		24'h800000};

	initial forever #5 i_clk = ~i_clk;

	sfp_front_end dut (
		.i_clk                 (i_clk),
		.i_rst_n               (i_rst_n),
		.i_sck                 (sck),
		.i_cs_n                (cs_n),
		.i_lane_zero_in        (lane[0]),
		.i_lane_one_in         (lane[1]),
		.i_lane_two_in         (lane[2]),
		.i_lane_three_in       (lane[3]),
		.o_lane_zero_out       (l_out[0]),
		.o_lane_zero_oe        (l_oe[0]),
		.o_lane_one_out        (l_out[1]),
		.o_lane_one_oe         (l_oe[1]),
		.o_lane_two_out        (l_out[2]),
		.o_lane_two_oe         (l_oe[2]),
		.o_lane_three_out      (l_out[3]),
		.o_lane_three_oe       (l_oe[3]),
		.i_quad_lane_enable    (cfg[5]),
		.i_pin_function_select (cfg[4]),
		.i_reset_pin_disable   (cfg[3]),
		.i_dual_mode           (cfg[2]),
		.i_quad_mode           (cfg[1]),
		.i_quad_command_mode   (cfg[0]),
		.i_rx_len              (rx_len),
		.i_tx_load             (tx_load),
		.i_tx_byte             (tx_byte),
		.i_addr                (addr),
		.o_rx_byte             (rx_byte),
		.o_rx_valid            (rx_valid),
		.o_pin_role            (role),
		.o_link_paused         (paused),
		.o_link_in_reset       (in_rst),
		.o_sector              (sector),
		.o_block32             (blk32),
		.o_block64             (blk64),
		.o_addr_in_range       (in_range)
	);

	sfp_spi_master m (
		.o_sck  (sck),
		.o_cs_n (cs_n),
		.o_lane (lane),
		.i_out  (l_out),
		.i_oe   (l_oe),
		.i_stat ({in_rst, paused})
	);

	// Every received byte is queued for comparison with what was sent
	always @(posedge i_clk)
		if (rx_valid === 1'b1)
			rxq.push_back(rx_byte);

	// A hang is cut short well beyond the expected run length
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s %0h not %0h", $time, what, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick

	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic cfg_set(input logic [5:0] c, input logic mode3);
		@(posedge i_clk);
		cfg <= c;
		tick(2);
		m.setup(mode3);
	endtask : cfg_set

	// Load the holding byte while deselected, run a frame, compare
	task automatic run(input int w, input int hold_at);
		logic [7:0] tx;
		logic [7:0] d;
		tx = 8'($urandom);
		d = 8'($urandom);
		@(posedge i_clk);
		tx_load <= 1'b1;
		tx_byte <= tx;
		@(posedge i_clk);
		tx_load <= 1'b0;
		rxq.delete();
		m.frame(w, d, int'(rx_len), 2, hold_at, rx_d);
		tick(10);
		chk(rxq.size(), rx_len, "byte count");
		for (int i = 0; i < int'(rx_len); i++)
			chk(rxq[i], d, "rx byte");
		chk(rx_d, tx, "tx byte");
		chk(m.oe_bad, 0, "lane enables");
	endtask : run

	initial begin
		int a;
		void'($urandom(32'hAE0B));
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		// Role of the shared pin for every combination of qe, select and reset off
		for (int c = 0; c < 8; c++) begin
			@(posedge i_clk);
			cfg <= {c[2:0], 3'h0};
			tick(2);
			#1;
			chk(role, c[2] ? SFP_ROLE_DATA : (c[1] & c[0]) ? SFP_ROLE_RESET
				: SFP_ROLE_PAUSE, "role");
		end
		$display("role test done");
		// Address map at the boundaries and at random
		for (int i = 0; i < 17; i++) begin
			a = (i < 9) ? int'(a_tab[i]) : int'(24'($urandom));
			@(posedge i_clk);
			addr <= 24'(a);
			tick(1);
			#1;
			chk(sector, (a >> 12) % 2048, "sector");
			chk(blk32, (a >> 15) % 256, "block32");
			chk(blk64, (a >> 16) % 128, "block64");
			chk(in_range, a <= 8388607, "range");
		end
		$display("map test done");
		// Each lane width, both clock modes; one input byte for single, two for dual, one and two for quad
		for (int t = 0; t < 8; t++) begin
			rx_len <= 4'((t % 2) + 1);
			cfg_set(cfg_tab[t % 4], t >= 4);
			run(w_tab[t % 4], -1);
		end
		$display("link test done");
		// Pause in the input and in the output phase
		rx_len <= 4'h1;
		cfg_set(6'h00, 1'b0);
		for (int h = 3; h < 12; h += 8) begin
			run(1, h);
			chk(m.hold_stat, 2'b01, "paused");
			chk(m.hold_oe, 4'h0, "paused enables");
		end
		m.drv[3] = 1'b0;
		tick(10);
		chk(paused, 1'b0, "deselected pause");
		m.drv[3] = 1'b1;
		$display("pause test done");
		// Select bit on, dedicated reset on and then off
		// Reset pin pulled only mid read, never during a write
		for (int r = 0; r < 2; r++) begin
			cfg_set({2'b01, r[0], 3'h0}, 1'b0);
			m.frame(1, 8'h5A, 1, 1, 11, rx_d);
			tick(4);
			chk(m.hold_stat, r ? 2'b10 : 2'b01, "pin use");
			chk(m.hold_oe, 4'h0, "released");
		end
		$display("reset pin test done");
		test_done();
	end

endmodule : test_serial_flash_pin_mode_front_end
